// ---- hdl/plug_resp_regs.vh ----
// constants for the cable-plug mode and status responder
// assumes messages arrive already decoded by a PD protocol layer
// Functional notes
// - Discover Modes reply echoes the SVID taken from the request.
// - Discover Modes reply announces four objects: VDM header, three modes.
// - A Get_Status addressed to the plug always gets a Status reply.
// - Status over SOP'/SOP" reports the plug's own condition only.
// - Status uses extended header, data size 2: temperature then flags.
// - Temperature byte: 0 unsupported, 1 below 2 C, 2..255 degrees C.
// - Flags bit 0 is thermal shutdown; bits 1 to 7 are zero.
`ifndef PLUG_RESP_REGS_VH
`define PLUG_RESP_REGS_VH

// =====================================================================
// framing and message codes
`define SOP_TYPE_SOP 2'h0
`define SOP_TYPE_SOP_P 2'h1
`define SOP_TYPE_SOP_PP 2'h2
`define MSG_GET_STATUS 5'h12
`define MSG_STATUS 5'h02
`define MSG_VENDOR 5'h0f
`define VDM_CMD_DISC_MODES 5'h03
`define VDM_CMD_TYPE_ACK 2'h1
`define VDM_STRUCT_BIT 15

// =====================================================================
// reply layout
`define MODES_NUM_OBJ 3'h4
`define MODES_WORDS 3'h4
`define STATUS_DATA_SIZE 9'h002
`define STATUS_WORDS 3'h2
`define NO_DATA_OBJ 3'h0
`define NO_DATA_SIZE 9'h000
`define TEMP_UNSUPPORTED 8'h00
`define TEMP_BELOW_TWO 8'h01
`define TEMP_MIN_DIRECT 8'h02
`define FLAG_SHUTDOWN_BIT 0

// =====================================================================
// reset values
`define MODE_OBJ_RESET 32'h00000000
`define MSG_RESET 5'h00
`define IDX_RESET 3'h0

`endif

// ---- hdl/plug_status_block.v ----
// builds the two-byte status data block of the plug
// assumes temp_c is the plug's signed sensor reading in whole degrees
`timescale 1ns/1ps
`include "plug_resp_regs.vh"

module plug_status_block (
    input wire temp_valid,
    input wire [8:0] temp_c,
    input wire shutdown,
    output reg [7:0] temp_byte,
    output wire [7:0] flags_byte
);

    // negative or small readings fold into the "below 2" code
    always @* begin
        if (!temp_valid) begin
            temp_byte = `TEMP_UNSUPPORTED;
        end else if (temp_c[8] || temp_c[7:0] < `TEMP_MIN_DIRECT) begin
            temp_byte = `TEMP_BELOW_TWO;
        end else begin
            temp_byte = temp_c[7:0];
        end
    end

    assign flags_byte = {7'h00, shutdown};

endmodule

// ---- hdl/plug_resp.v ----
// cable-plug responder for Discover Modes and Get_Status
// assumes a protocol layer delivering one decoded request per pulse
// and taking reply words one at a time with valid/ready
`timescale 1ns/1ps
`include "plug_resp_regs.vh"

module plug_resp (
    input wire clk,
    input wire rst,
    input wire req_valid,
    input wire [1:0] req_sop,
    input wire req_ext,
    input wire [4:0] req_msg,
    input wire [31:0] req_vdm_hdr,
    output wire req_ready,
    input wire [31:0] mode1_vdo,
    input wire [31:0] mode2_vdo,
    input wire [31:0] mode3_vdo,
    input wire temp_valid,
    input wire [8:0] temp_c,
    input wire shutdown,
    output reg rsp_valid,
    output reg [1:0] rsp_sop,
    output reg rsp_ext,
    output reg [4:0] rsp_msg,
    output reg [2:0] rsp_num_obj,
    output reg [8:0] rsp_data_size,
    output reg [31:0] rsp_word,
    output reg rsp_last,
    input wire rsp_ready
);

    // =================================================================
    // state and storage
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    reg state_q;
    reg state_d;
    reg [2:0] idx_q;
    reg [2:0] idx_d;
    reg [2:0] total_q;
    reg [2:0] total_d;
    wire [31:0] load_word [0:3];
    wire [31:0] buf_word [0:3];
    wire [31:0] modes_hdr;
    wire [31:0] status_ext;
    wire [31:0] status_sdb;
    wire [31:0] next_word;
    wire [2:0] last_idx;
    wire [7:0] temp_byte;
    wire [7:0] flags_byte;
    wire addr_plug;
    wire is_vdm;
    wire is_disc_modes;
    wire is_modes;
    wire is_status;
    wire accept;
    wire word_taken;
    wire last_taken;
    genvar g;

    // =================================================================
    // plug condition
    // the temperature code is worked out here so the sequencer only
    // has to latch bytes
    plug_status_block u_status (
        .temp_valid(temp_valid),
        .temp_c(temp_c),
        .shutdown(shutdown),
        .temp_byte(temp_byte),
        .flags_byte(flags_byte)
    );

    // =================================================================
    // request decode
    // only the plug's own framings are answered; sop traffic is meant
    // for the port partner and is dropped
    assign addr_plug = (req_sop == `SOP_TYPE_SOP_P) ||
                       (req_sop == `SOP_TYPE_SOP_PP);
    assign is_vdm = !req_ext && (req_msg == `MSG_VENDOR);
    assign is_disc_modes = req_vdm_hdr[`VDM_STRUCT_BIT] &&
                           (req_vdm_hdr[4:0] == `VDM_CMD_DISC_MODES);
    assign is_modes = is_vdm && is_disc_modes;
    assign is_status = !req_ext && (req_msg == `MSG_GET_STATUS);
    // unmatched requests are still taken, so a stray message never
    // stalls the request side
    assign req_ready = (state_q == ST_IDLE);
    assign accept = req_valid && req_ready && addr_plug &&
                    (is_modes || is_status);

    // =================================================================
    // reply words
    // svid, structured bit, version and position return as received;
    // bit 7 clears and the command type turns into ack
    assign modes_hdr = {req_vdm_hdr[31:8], 1'b0, `VDM_CMD_TYPE_ACK,
                        `VDM_CMD_DISC_MODES};
    // status word 0 carries only the extended-header data size
    assign status_ext = {23'h000000, `STATUS_DATA_SIZE};
    // built from the plug's own sensor whatever the framing, since the
    // plug has no view of the port partner
    assign status_sdb = {16'h0000, flags_byte, temp_byte};
    assign load_word[0] = is_modes ? modes_hdr : status_ext;
    assign load_word[1] = is_modes ? mode1_vdo : status_sdb;
    assign load_word[2] = is_modes ? mode2_vdo : `MODE_OBJ_RESET;
    assign load_word[3] = is_modes ? mode3_vdo : `MODE_OBJ_RESET;

    // =================================================================
    // reply buffer, one word of flip-flops per entry
    // loaded whole at acceptance, so later input changes cannot leak
    // into a reply already under way
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_buf
            reg [31:0] word_q;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    word_q <= `MODE_OBJ_RESET;
                end else if (accept) begin
                    word_q <= load_word[g];
                end
            end
            assign buf_word[g] = word_q;
        end
    endgenerate

    // =================================================================
    // reply sequencer
    // idx_q points at the buffer entry that goes out next
    assign word_taken = rsp_valid && rsp_ready;
    assign last_taken = word_taken && rsp_last;
    assign last_idx = total_q - 3'h1;
    assign next_word = buf_word[idx_q[1:0]];

    always @* begin
        state_d = state_q;
        idx_d = idx_q;
        total_d = total_q;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    state_d = ST_SEND;
                    idx_d = 3'h1;
                    if (is_modes) begin
                        total_d = `MODES_WORDS;
                    end else begin
                        total_d = `STATUS_WORDS;
                    end
                end
            end
            ST_SEND: begin
                if (last_taken) begin
                    state_d = ST_IDLE;
                end else if (word_taken) begin
                    idx_d = idx_q + 3'h1;
                end
            end
            // unreachable with a one-bit state, kept as a safe exit
            default: begin
                state_d = ST_IDLE;
                idx_d = `IDX_RESET;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            idx_q <= `IDX_RESET;
            total_q <= `IDX_RESET;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            total_q <= total_d;
        end
    end

    // =================================================================
    // reply header fields, fixed for the whole reply
    // ignored by the consumer while rsp_valid is low
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_sop <= `SOP_TYPE_SOP;
            rsp_ext <= 1'b0;
            rsp_msg <= `MSG_RESET;
            rsp_num_obj <= `NO_DATA_OBJ;
            rsp_data_size <= `NO_DATA_SIZE;
        end else if (accept) begin
            rsp_sop <= req_sop;
            if (is_modes) begin
                rsp_ext <= 1'b0;
                rsp_msg <= `MSG_VENDOR;
                rsp_num_obj <= `MODES_NUM_OBJ;
                rsp_data_size <= `NO_DATA_SIZE;
            end else begin
                rsp_ext <= 1'b1;
                rsp_msg <= `MSG_STATUS;
                rsp_num_obj <= `NO_DATA_OBJ;
                rsp_data_size <= `STATUS_DATA_SIZE;
            end
        end
    end

    // =================================================================
    // word stream towards the protocol layer
    // rsp_last rides with the final word so the consumer needs no count;
    // a stalled consumer simply holds the current word in place
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_word <= `MODE_OBJ_RESET;
            rsp_last <= 1'b0;
        end else if (accept) begin
            rsp_valid <= 1'b1;
            rsp_word <= load_word[0];
            rsp_last <= 1'b0;
        end else if (last_taken) begin
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
        end else if (word_taken) begin
            rsp_word <= next_word;
            rsp_last <= (idx_q == last_idx);
        end
    end

endmodule

// ---- testbench/plug_resp_chk.sv ----
// assertions on the plug responder ports
// assumes it is bound into plug_resp
`timescale 1ns/1ps
module plug_resp_chk (
    input wire clk,
    input wire rst,
    input wire req_valid,
    input wire req_ready,
    input wire req_ext,
    input wire temp_valid,
    input wire shutdown,
    input wire rsp_valid,
    input wire rsp_last,
    input wire [1:0] req_sop,
    input wire [1:0] rsp_sop,
    input wire [2:0] rsp_num_obj,
    input wire [4:0] req_msg,
    input wire [4:0] rsp_msg,
    input wire [8:0] temp_c,
    input wire [8:0] rsp_data_size,
    input wire [31:0] req_vdm_hdr,
    input wire [31:0] rsp_word
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire acc = req_valid && req_ready && req_sop != 2'h0 && !req_ext;
    wire st = rsp_valid && rsp_msg == 5'h02;
    // code held from acceptance, the sensor may drift meanwhile
    reg [7:0] t_q;
    reg sd_q;
    always @(posedge clk) if (acc) t_q <= !temp_valid ? 8'h00 :
        temp_c[8] || temp_c < 9'h002 ? 8'h01 : temp_c[7:0];
    always @(posedge clk) if (acc) sd_q <= shutdown;
    property p_echo; acc && req_msg == 5'h0f |=> !rsp_valid ||
        rsp_word[31:16] == $past(req_vdm_hdr[31:16]); endproperty
    a_echo: assert property (p_echo) else $error("svid");
    property p_nobj; rsp_valid && !st |-> rsp_num_obj == 3'h4; endproperty
    a_nobj: assert property (p_nobj) else $error("count");
    property p_ans; acc && req_msg == 5'h12 |=> st; endproperty
    a_ans: assert property (p_ans) else $error("no status");
    property p_own; acc |=> !rsp_valid || rsp_sop == $past(req_sop);
        endproperty
    a_own: assert property (p_own) else $error("framing");
    property p_size; st |-> rsp_data_size == 9'h002; endproperty
    a_size: assert property (p_size) else $error("size");
    property p_temp; st && rsp_last |-> rsp_word[7:0] == t_q; endproperty
    a_temp: assert property (p_temp) else $error("temp");
    property p_flag; st && rsp_last |-> rsp_word[15:8] == {7'h00, sd_q};
        endproperty
    a_flag: assert property (p_flag) else $error("flags");
    property p_sop; req_valid && req_ready && req_sop == 2'h0 |=> !rsp_valid;
        endproperty
    a_sop: assert property (p_sop) else $error("sop");
endmodule
bind plug_resp plug_resp_chk i_plug_resp_chk (.*);

// ---- testbench/pd_port_model.sv ----
// reply consumer in place of the port controller
// assumes the bench seeds the generator
`timescale 1ns/1ps
module pd_port_model (
    input wire clk,
    output reg rsp_ready = 1'b0
);
    always @(posedge clk) rsp_ready <= $urandom_range(1, 0);
endmodule

// ---- testbench/testbench.sv ----
// random and corner requests against the plug responder
// assumes the stalling reply model on the far side
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0, rst = 1'b1, rv = 1'b0, ext = 1'b0, tv = 1'b0;
    reg sd = 1'b0, st, md;
    reg [1:0] sop = 2'h0;
    reg [4:0] msg = 5'h00;
    reg [8:0] tc = 9'h000;
    reg [19:0] gh;
    reg [31:0] hdr = 32'h0, mv [1:3] = '{0, 0, 0}, w [0:3];
    wire ov, ry, rr, ol;
    wire [19:0] oh;
    wire [31:0] ow;
    int miscompares = 0, check_count = 0, n, lw, bz;
    plug_resp i_plug_resp (.clk(clk), .rst(rst), .req_valid(rv),
        .req_sop(sop), .req_ext(ext), .req_msg(msg), .req_vdm_hdr(hdr),
        .req_ready(rr), .mode1_vdo(mv[1]), .mode2_vdo(mv[2]),
        .mode3_vdo(mv[3]), .temp_valid(tv), .temp_c(tc), .shutdown(sd),
        .rsp_valid(ov), .rsp_sop(oh[19:18]), .rsp_ext(oh[17]),
        .rsp_msg(oh[16:12]), .rsp_num_obj(oh[11:9]),
        .rsp_data_size(oh[8:0]), .rsp_word(ow), .rsp_last(ol),
        .rsp_ready(ry));
    pd_port_model i_pd_port_model (.clk(clk), .rsp_ready(ry));
    initial forever #2.5 clk = ~clk;
    initial begin #20000; miscompares++; tally_and_finish; end
    function logic [7:0] et(input logic v, input logic [8:0] t);
        et = !v ? 8'h00 : t[8] || t < 9'h002 ? 8'h01 : t[7:0];
    endfunction
    task chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) miscompares++;
        if (s !== e) $display("MISMATCH %s exp %h seen %h", nm, e, s);
    endtask
    task tally_and_finish;
        if (!miscompares && check_count) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hf878));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            {sop, ext, tv, sd} <= {2'($urandom_range(2, 0)), i % 9 == 8,
                i < 6 || i[1], 1'($urandom)};
            msg <= i % 3 == 2 ? 5'h01 : i[0] ? 5'h12 : 5'h0f;
            hdr <= {16'($urandom), i % 5 != 4, 10'h0, i % 7 ? 5'h03 : 5'h04};
            foreach (mv[k]) mv[k] <= $urandom;
            // first temps sit on the 0, 1 and 2 code edges
            tc <= i < 3 ? 9'(i) : 9'($urandom);
            rv <= 1'b1;
            // hold the request until an edge finds the responder idle
            do @(posedge clk); while (!rr);
            rv <= 1'b0;
            st = sop != 2'h0 && !ext && msg == 5'h12;
            md = sop != 2'h0 && !ext && msg == 5'h0f && hdr[15] &&
                hdr[4:0] == 5'h03;
            n = 0;
            lw = 0;
            bz = 0;
            repeat (40) begin
                @(posedge clk);
                if (ov) gh = oh;
                if (ov && rr) bz = 1;
                if (ov && ry && ol) lw = n + 1;
                if (ov && ry) w[n[1:0]] = ow;
                n += ov && ry;
            end
            chk("words", n, st ? 2 : md ? 4 : 0);
            chk("last", lw, st ? 2 : md ? 4 : 0);
            chk("busy", bz, 0);
            if (st) chk("st", gh, {sop, 1'b1, 5'h02, 12'h002});
            if (st) chk("w0", w[0], 32'h2);
            if (st) chk("w1", w[1], {23'h0, sd, et(tv, tc)});
            if (md) chk("md", gh, {sop, 1'b0, 5'h0f, 12'h800});
            if (md) chk("vdm", w[0], {hdr[31:8], 8'h23});
            if (md) foreach (mv[k]) chk("mode", w[k], mv[k]);
        end
        tally_and_finish;
    end
endmodule
